// [pll_reconfig_calibration_control_test.sv]
`timescale 1ns/100ps
`include "plrc_consts.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module pll_reconfig_calibration_control_test;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [31:0] rd;
  reg err;
  bit ok;
  int n_mismatch = 0;
  int checks_done = 0;
  wire [31:0] prdata;
  wire pready, pslverr, areset, sw_n, p_tog, b_tog, locked, active, cal_busy;
  always #2 ref_clk = ~ref_clk;
  plrc_top #(.CAL_CYCLES(16'h0004), .LOCK_CYCLES(16'h0004),
    .RELOCK_CYCLES(16'h0006), .RETRY_CYCLES(16'h0008)) uut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PLL_ARESET(areset), .SWITCH_N(sw_n),
    .REF_PRIMARY_TOGGLING(p_tog), .REF_BACKUP_TOGGLING(b_tog), .LOCKED(locked),
    .ACTIVE_REF(active), .PRIMARY_REF_FAILED(), .BACKUP_REF_FAILED(),
    .CAL_BUSY(cal_busy));
  plrc_fabric fab (.ref_clk(ref_clk), .locked(locked), .pll_areset(areset),
    .switch_n(sw_n), .prim_tog(p_tog), .back_tog(b_tog));
  // one apb transfer; the request stands until ready is sampled
  task apb(input wr, input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin @(posedge ref_clk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  task wait_lock;
    int i;
    // one edge first, so a lock dropped at the caller's edge is seen
    @(posedge ref_clk);
    for (i = 0; i < 100 && locked !== 1'b1; i++) @(posedge ref_clk);
  endtask
  task t_cal;
    int i;
    repeat (20) @(posedge ref_clk);
    `CHK(cal_busy, 1'b0)
    apb(1'b0, `PLRC_STATUS_OFS, 32'h0000_0000);
    `CHK(rd[`PLRC_ST_PRIM_FAIL], 1'b1)
    `CHK(rd[`PLRC_ST_BACK_FAIL], 1'b1)
    fab.refs(1'b1, 1'b1);
    for (i = 0; i < 30 && cal_busy !== 1'b1; i++) @(posedge ref_clk);
    `CHK(cal_busy, 1'b1)
    wait_lock();
    `CHK(locked, 1'b1)
    $display("t_cal done");
  endtask
  task t_regs;
    rdchk(`PLRC_MN_OFS, {16'h0000, `PLRC_MN_RST});
    rdchk(`PLRC_BWLF_OFS, {23'h00_0000, `PLRC_BWLF_RST});
    rdchk(`PLRC_CDIV_OFS, {8'h00, `PLRC_CDIV_RST});
    apb(1'b0, 8'hFC, 32'h0000_0000);
    `CHK(err, 1'b1)
    $display("t_regs done");
  endtask
  task t_reconf;
    apb(1'b1, `PLRC_MN_OFS, 32'h0000_0220);
    apb(1'b1, `PLRC_BWLF_OFS, 32'h0000_0080);
    apb(1'b1, `PLRC_CTRL_OFS, 32'h0000_0001);
    apb(1'b0, `PLRC_STATUS_OFS, 32'h0000_0000);
    `CHK(rd[`PLRC_ST_RECAL_NEED], 1'b1)
    `CHK(rd[`PLRC_ST_LOCKED], 1'b0)
    apb(1'b1, `PLRC_CTRL_OFS, 32'h0000_000A);
    wait_lock();
    `CHK(locked, 1'b1)
    rdchk(`PLRC_ACTMN_OFS, 32'h0080_0220);
    $display("t_reconf done");
  endtask
  // waits, bounded, for the phase engine to go idle
  task ph_run(input [31:0] cmd);
    int i;
    apb(1'b1, `PLRC_PHASE_OFS, cmd);
    i = 0;
    do begin apb(1'b0, `PLRC_STATUS_OFS, 32'h0000_0000); i++; end
    while (rd[`PLRC_ST_PH_BUSY] !== 1'b0 && i < 20);
  endtask
  task t_phase;
    ph_run(32'h8000_0103);
    rdchk(`PLRC_PHOFS_OFS, 32'h0000_0003);
    ph_run(32'h8000_0201);
    rdchk(`PLRC_PHOFS_OFS, 32'h0000_FF03);
    `CHK(locked, 1'b1)
    fab.pll_reset(ok);
    `CHK(ok, 1'b1)
    rdchk(`PLRC_PHOFS_OFS, 32'h0000_0000);
    rdchk(`PLRC_ACTMN_OFS, 32'h0080_0220);
    $display("t_phase done");
  endtask
  task t_switch;
    int i;
    bit seen;
    seen = 1'b0;
    fab.switch_over();
    `CHK(active, 1'b1)
    for (i = 0; i < 100 && locked !== 1'b1; i++) begin
      @(posedge ref_clk);
      seen = seen | cal_busy;
    end
    `CHK(seen, 1'b0)
    `CHK(locked, 1'b1)
    $display("t_switch done");
  endtask
  // automatic mode: the active backup stops, the primary takes over
  task t_auto;
    apb(1'b1, `PLRC_CTRL_OFS, 32'h0000_000C);
    fab.refs(1'b1, 1'b0);
    repeat (2) @(posedge ref_clk);
    `CHK(locked, 1'b0)
    `CHK(active, 1'b0)
    wait_lock();
    `CHK(locked, 1'b1)
    $display("t_auto done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_cal();
    t_regs();
    t_reconf();
    t_phase();
    t_switch();
    t_auto();
    wrap_up();
  end
  // watchdog, far beyond the 140 or so cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
endmodule // pll_reconfig_calibration_control_test

// [plrc_consts.vh]
`ifndef PLRC_CONSTS_VH
`define PLRC_CONSTS_VH

// register byte offsets
`define PLRC_CTRL_OFS 8'h00
`define PLRC_MN_OFS 8'h04
`define PLRC_BWLF_OFS 8'h08
`define PLRC_CDIV_OFS 8'h0C
`define PLRC_PHASE_OFS 8'h10
`define PLRC_STATUS_OFS 8'h14
`define PLRC_PHOFS_OFS 8'h18
`define PLRC_ACTMN_OFS 8'h1C
`define PLRC_ACTC_OFS 8'h20

// control fields
`define PLRC_CTRL_COMMIT 0
`define PLRC_CTRL_RECAL 1
`define PLRC_CTRL_AUTO_EN 2
`define PLRC_CTRL_SWO_EN 3

// phase command fields
`define PLRC_PH_DIR 8
`define PLRC_PH_SEL_LO 9
`define PLRC_PH_SEL_HI 10
`define PLRC_PH_START 31

// status fields
`define PLRC_ST_LOCKED 0
`define PLRC_ST_CAL_BUSY 1
`define PLRC_ST_CAL_DONE_LO 2
`define PLRC_ST_ACTIVE 4
`define PLRC_ST_PRIM_FAIL 5
`define PLRC_ST_BACK_FAIL 6
`define PLRC_ST_PH_BUSY 7
`define PLRC_ST_RECAL_NEED 8

// reset values
`define PLRC_MN_RST 16'h0110
`define PLRC_BWLF_RST 9'h040
`define PLRC_CDIV_RST 24'h04_0404
`define PLRC_CTRL_RST 2'b00

// phase shift step is one eighth of the vco period
`define PLRC_PH_STEPS_PER_VCO 4'h8
// manual switch low time, in sampled REF_CLK cycles
`define PLRC_SW_HOLD_CYC 4'h3
// user-side least reset hold after a switchover
`define PLRC_RST_MIN_NS 10
`define PLRC_CLK_PERIOD_NS 4
`define PLRC_RST_MIN_CYC ((`PLRC_RST_MIN_NS + `PLRC_CLK_PERIOD_NS - 1) / `PLRC_CLK_PERIOD_NS)

`endif

// [plrc_fabric.sv]
`timescale 1ns/100ps
`include "plrc_consts.vh"
module plrc_fabric (
  input wire ref_clk,
  input wire locked,
  output reg pll_areset,
  output reg switch_n,
  output reg prim_tog,
  output reg back_tog
);
  // references start absent so calibration must wait for them
  initial begin
    pll_areset = 1'b0;
    switch_n = 1'b1;
    prim_tog = 1'b0;
    back_tog = 1'b0;
  end
  // sets which references run; switchover calibration needs both
  task refs(input p, input b);
    @(posedge ref_clk);
    prim_tog <= p;
    back_tog <= b;
  endtask
  // reset held past the minimum, then waits up to 100 cycles for lock
  task pll_reset(output bit ok);
    int i;
    @(posedge ref_clk);
    pll_areset <= 1'b1;
    repeat (`PLRC_RST_MIN_CYC) @(posedge ref_clk);
    pll_areset <= 1'b0;
    for (i = 0; i < 100 && locked !== 1'b1; i++) @(posedge ref_clk);
    ok = (locked === 1'b1);
  endtask
  // falling edge only with both references up, then held low
  task switch_over;
    @(posedge ref_clk);
    if (prim_tog && back_tog) switch_n <= 1'b0;
    repeat (`PLRC_SW_HOLD_CYC + 2) @(posedge ref_clk);
    switch_n <= 1'b1;
  endtask
endmodule // plrc_fabric

// [plrc_properties.sv]
`timescale 1ns/100ps
module plrc_checker #(
  parameter [15:0] CAL_CYCLES = 16'h0004
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire PLL_ARESET,
  input wire SWITCH_N,
  input wire REF_PRIMARY_TOGGLING,
  input wire LOCKED,
  input wire ACTIVE_REF,
  input wire PRIMARY_REF_FAILED,
  input wire CAL_BUSY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  reg [15:0] cal_run;
  // counts the current calibration run; a stuck engine shows up here
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) cal_run <= 16'h0000;
    else cal_run <= CAL_BUSY ? cal_run + 16'h0001 : 16'h0000;
  end
  sequence apb_setup;
    PSEL && !PENABLE;
  endsequence
  sequence cal_end;
    $fell(CAL_BUSY) && !PLL_ARESET;
  endsequence
  pready_access_a: assert property (apb_setup |=> PREADY)
    else $error("no ready in access cycle");
  pready_single_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  slverr_access_a: assert property (PSLVERR |-> PREADY)
    else $error("error outside access cycle");
  reset_unlock_a: assert property (PLL_ARESET |=> !LOCKED)
    else $error("lock kept during pll reset");
  fail_flag_a: assert property ($past(RST_N) |->
    PRIMARY_REF_FAILED == !$past(REF_PRIMARY_TOGGLING))
    else $error("failure flag wrong");
  cal_unlocked_a: assert property (CAL_BUSY |-> !LOCKED)
    else $error("locked while calibrating");
  lock_after_cal_a: assert property (cal_end |-> ##[1:12] (LOCKED || PLL_ARESET))
    else $error("no lock after calibration");
  cal_length_a: assert property (cal_run <= CAL_CYCLES + 16'h0001)
    else $error("calibration too long");
  switch_unlock_a: assert property ($changed(ACTIVE_REF) |-> !LOCKED)
    else $error("lock kept over switchover");
  switch_hold_a: assert property ($changed(ACTIVE_REF) && !$past(SWITCH_N, 1) |->
    !$past(SWITCH_N, 2) && !$past(SWITCH_N, 3))
    else $error("switch without low hold");
endmodule // plrc_checker

bind plrc_top plrc_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PLL_ARESET(PLL_ARESET),
  .SWITCH_N(SWITCH_N), .REF_PRIMARY_TOGGLING(REF_PRIMARY_TOGGLING),
  .LOCKED(LOCKED), .ACTIVE_REF(ACTIVE_REF),
  .PRIMARY_REF_FAILED(PRIMARY_REF_FAILED), .CAL_BUSY(CAL_BUSY));

// [plrc_top.v]
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "plrc_consts.vh"
module plrc_top #(
  parameter [15:0] CAL_CYCLES = 16'h03E8,
  parameter [15:0] LOCK_CYCLES = 16'h00C8,
  parameter [15:0] RELOCK_CYCLES = 16'h0190,
  parameter [15:0] RETRY_CYCLES = 16'h1388
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire PLL_ARESET,
  input wire SWITCH_N,
  input wire REF_PRIMARY_TOGGLING,
  input wire REF_BACKUP_TOGGLING,
  output reg LOCKED,
  output reg ACTIVE_REF,
  output reg PRIMARY_REF_FAILED,
  output reg BACKUP_REF_FAILED,
  output reg CAL_BUSY
);

  localparam N_OUT = 3;
  localparam [1:0] ST_WAIT = 2'd0;
  localparam [1:0] ST_CAL = 2'd1;
  localparam [1:0] ST_LOCKING = 2'd2;
  localparam [1:0] ST_LOCKED = 2'd3;
  localparam [3:0] IDX_NONE = 4'hF;

  // address decode shared by read and write paths
  function [3:0] plrc_decode;
    input [7:0] addr;
    begin
      case (addr)
        `PLRC_CTRL_OFS: plrc_decode = 4'h0;
        `PLRC_MN_OFS: plrc_decode = 4'h1;
        `PLRC_BWLF_OFS: plrc_decode = 4'h2;
        `PLRC_CDIV_OFS: plrc_decode = 4'h3;
        `PLRC_PHASE_OFS: plrc_decode = 4'h4;
        `PLRC_STATUS_OFS: plrc_decode = 4'h5;
        `PLRC_PHOFS_OFS: plrc_decode = 4'h6;
        `PLRC_ACTMN_OFS: plrc_decode = 4'h7;
        `PLRC_ACTC_OFS: plrc_decode = 4'h8;
        default: plrc_decode = IDX_NONE;
      endcase
    end
  endfunction

  reg [1:0] ctrl;
  reg [15:0] mn_shadow;
  reg [8:0] bwlf_shadow;
  reg [23:0] c_shadow;
  reg [15:0] mn_act;
  reg [8:0] bwlf_act;
  reg [23:0] c_act;
  reg recal_needed;
  reg [1:0] state;
  reg [15:0] cnt;
  reg [15:0] lock_target;
  reg cal_pending;
  reg [1:0] cal_done;
  reg sw_prev;
  reg sw_armed;
  reg [3:0] sw_low_cnt;
  reg ph_busy;
  reg ph_dir;
  reg [1:0] ph_sel;
  reg [7:0] ph_left;
  reg [7:0] ph_ofs [0:N_OUT-1];
  reg [31:0] next_prdata;

  wire [3:0] wr_idx = plrc_decode(PADDR);
  wire wr_en = PSEL & PENABLE & PREADY & PWRITE;
  wire commit = wr_en & (wr_idx == 4'h0) & PWDATA[`PLRC_CTRL_COMMIT];
  wire recal_req = wr_en & (wr_idx == 4'h0) & PWDATA[`PLRC_CTRL_RECAL];
  wire ph_start = wr_en & (wr_idx == 4'h4) & PWDATA[`PLRC_PH_START];
  wire auto_en = ctrl[0];
  wire swo_en = ctrl[1];
  wire act_ok = ACTIVE_REF ? REF_BACKUP_TOGGLING : REF_PRIMARY_TOGGLING;
  wire other_ok = ACTIVE_REF ? REF_PRIMARY_TOGGLING : REF_BACKUP_TOGGLING;
  wire both_ok = REF_PRIMARY_TOGGLING & REF_BACKUP_TOGGLING;
  wire refs_ready = swo_en ? both_ok : act_ok;
  // switch fires only once the target reference is available
  wire man_fire = sw_armed & ~SWITCH_N & (sw_low_cnt >= `PLRC_SW_HOLD_CYC) & other_ok;
  // a held-low manual switch blocks automatic action
  wire auto_fire = auto_en & SWITCH_N & ~act_ok & other_ok;
  wire sw_fire = man_fire | auto_fire;
  wire ph_step = ph_busy & LOCKED & ~PLL_ARESET;

  // apb slave: zero wait states, read data and error prepared in setup
  always @* begin
    case (plrc_decode(PADDR))
      4'h0: next_prdata = {28'h000_0000, ctrl, 2'b00};
      4'h1: next_prdata = {16'h0000, mn_shadow};
      4'h2: next_prdata = {23'h00_0000, bwlf_shadow};
      4'h3: next_prdata = {8'h00, c_shadow};
      4'h4: next_prdata = {21'h00_0000, ph_sel, ph_dir, ph_left};
      4'h5: next_prdata = {23'h00_0000, recal_needed, ph_busy, BACKUP_REF_FAILED,
                           PRIMARY_REF_FAILED, ACTIVE_REF, cal_done, CAL_BUSY, LOCKED};
      4'h6: next_prdata = {8'h00, ph_ofs[2], ph_ofs[1], ph_ofs[0]};
      4'h7: next_prdata = {7'h00, bwlf_act, mn_act};
      4'h8: next_prdata = {8'h00, c_act};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & (plrc_decode(PADDR) == IDX_NONE);
      if (PSEL & ~PENABLE & ~PWRITE) begin
        PRDATA <= next_prdata;
      end
    end
  end

  // shadow settings take effect on commit; pll reset never touches them
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= `PLRC_CTRL_RST;
      mn_shadow <= `PLRC_MN_RST;
      bwlf_shadow <= `PLRC_BWLF_RST;
      c_shadow <= `PLRC_CDIV_RST;
      mn_act <= `PLRC_MN_RST;
      bwlf_act <= `PLRC_BWLF_RST;
      c_act <= `PLRC_CDIV_RST;
      recal_needed <= 1'b0;
    end else begin
      if (wr_en & (wr_idx == 4'h0)) begin
        ctrl <= {PWDATA[`PLRC_CTRL_SWO_EN], PWDATA[`PLRC_CTRL_AUTO_EN]};
      end
      if (wr_en & (wr_idx == 4'h1)) begin
        mn_shadow <= PWDATA[15:0];
      end
      if (wr_en & (wr_idx == 4'h2)) begin
        bwlf_shadow <= PWDATA[8:0];
      end
      if (wr_en & (wr_idx == 4'h3)) begin
        c_shadow <= PWDATA[23:0];
      end
      if (commit) begin
        mn_act <= mn_shadow;
        bwlf_act <= bwlf_shadow;
        c_act <= c_shadow;
      end
      // a new m/n needs recalibration; the set wins over the clear
      if (commit & (mn_shadow != mn_act)) begin
        recal_needed <= 1'b1;
      end else if (recal_req) begin
        recal_needed <= 1'b0;
      end
    end
  end

  // manual switch: falling edge arms only if both references toggle
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_prev <= 1'b1;
      sw_armed <= 1'b0;
      sw_low_cnt <= 4'h0;
    end else begin
      sw_prev <= SWITCH_N;
      if (sw_prev & ~SWITCH_N) begin
        sw_armed <= both_ok;
        sw_low_cnt <= 4'h1;
      end else if (~SWITCH_N & sw_armed) begin
        if (man_fire) begin
          sw_armed <= 1'b0;
        end else if (sw_low_cnt != 4'hF) begin
          sw_low_cnt <= sw_low_cnt + 4'h1;
        end
      end else if (SWITCH_N) begin
        sw_armed <= 1'b0;
      end
    end
  end

  // reference failure flags, meaningful only for close frequencies
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRIMARY_REF_FAILED <= 1'b0;
      BACKUP_REF_FAILED <= 1'b0;
    end else begin
      PRIMARY_REF_FAILED <= ~REF_PRIMARY_TOGGLING;
      BACKUP_REF_FAILED <= ~REF_BACKUP_TOGGLING;
    end
  end

  // calibration, lock and switchover sequencing
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_WAIT;
      cnt <= 16'h0000;
      lock_target <= LOCK_CYCLES;
      cal_pending <= 1'b1;
      cal_done <= 2'b00;
      LOCKED <= 1'b0;
      ACTIVE_REF <= 1'b0;
      CAL_BUSY <= 1'b0;
    end else begin
      case (state)
        ST_WAIT: begin
          LOCKED <= 1'b0;
          CAL_BUSY <= 1'b0;
          if (!cal_pending) begin
            state <= ST_LOCKING;
            cnt <= 16'h0000;
          end else if (cnt == 16'h0000) begin
            if (refs_ready) begin
              state <= ST_CAL;
              CAL_BUSY <= 1'b1;
            end else begin
              cnt <= 16'h0001;
            end
          end else if (cnt >= RETRY_CYCLES - 16'h0001) begin
            cnt <= 16'h0000;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_CAL: begin
          if (!refs_ready) begin
            state <= ST_WAIT;
            CAL_BUSY <= 1'b0;
            cnt <= 16'h0001;
          end else if (cnt >= CAL_CYCLES - 16'h0001) begin
            // results are kept per reference input
            cal_done <= swo_en ? 2'b11 : (cal_done | (ACTIVE_REF ? 2'b10 : 2'b01));
            cal_pending <= 1'b0;
            CAL_BUSY <= 1'b0;
            state <= ST_LOCKING;
            cnt <= 16'h0000;
            lock_target <= LOCK_CYCLES;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_LOCKING: begin
          LOCKED <= 1'b0;
          if (!act_ok | PLL_ARESET) begin
            cnt <= 16'h0000;
          end else if (cnt >= lock_target - 16'h0001) begin
            LOCKED <= 1'b1;
            state <= ST_LOCKED;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_LOCKED: begin
          if (!act_ok) begin
            LOCKED <= 1'b0;
            state <= ST_LOCKING;
            cnt <= 16'h0000;
            lock_target <= RELOCK_CYCLES;
          end
        end
        default: begin
          state <= ST_WAIT;
          cnt <= 16'h0000;
        end
      endcase
      // later assignments override the state walk above
      if (recal_req) begin
        cal_pending <= 1'b1;
        cal_done <= 2'b00;
        LOCKED <= 1'b0;
        CAL_BUSY <= 1'b0;
        state <= ST_WAIT;
        cnt <= 16'h0000;
      end else if (sw_fire) begin
        ACTIVE_REF <= ~ACTIVE_REF;
        LOCKED <= 1'b0;
        CAL_BUSY <= 1'b0; // a switch ends any run in progress, busy must not stick
        cnt <= 16'h0000;
        lock_target <= RELOCK_CYCLES;
        if (cal_done[~ACTIVE_REF]) begin
          state <= ST_LOCKING;
        end else begin
          cal_pending <= 1'b1;
          state <= ST_WAIT;
        end
      end else if (commit & state[1]) begin
        // new counters change frequency, so lock is lost and regained
        LOCKED <= 1'b0;
        state <= ST_LOCKING;
        cnt <= 16'h0000;
        lock_target <= LOCK_CYCLES;
      end else if (PLL_ARESET & state[1]) begin
        LOCKED <= 1'b0;
        state <= ST_LOCKING;
        cnt <= 16'h0000;
        lock_target <= LOCK_CYCLES;
      end
    end
  end

  // phase shift engine: one eighth-vco step per cycle while locked
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_busy <= 1'b0;
      ph_dir <= 1'b0;
      ph_sel <= 2'b00;
      ph_left <= 8'h00;
    end else if (PLL_ARESET) begin
      ph_busy <= 1'b0;
      ph_left <= 8'h00;
    end else if (ph_start & ~ph_busy) begin
      ph_busy <= (PWDATA[7:0] != 8'h00) &
                 (PWDATA[`PLRC_PH_SEL_HI:`PLRC_PH_SEL_LO] < N_OUT);
      ph_left <= PWDATA[7:0];
      ph_dir <= PWDATA[`PLRC_PH_DIR];
      ph_sel <= PWDATA[`PLRC_PH_SEL_HI:`PLRC_PH_SEL_LO];
    end else if (ph_step) begin
      ph_left <= ph_left - 8'h01;
      ph_busy <= (ph_left != 8'h01);
    end
  end

  // per-output phase offsets in eighths of a vco period, modulo 256
  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : gen_ofs
      always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          ph_ofs[g] <= 8'h00;
        end else if (PLL_ARESET) begin
          ph_ofs[g] <= 8'h00;
        end else if (ph_step && (ph_sel == g)) begin
          ph_ofs[g] <= ph_dir ? ph_ofs[g] + 8'h01 : ph_ofs[g] - 8'h01;
        end
      end
    end
  endgenerate

endmodule // plrc_top
